// ### src/ddr3_guard_defines.svh
// Constants of the DDR3 command timing guard: offsets, fields, timing counts
// How it works
// - Termination on and off latency: WL minus 2
// - Reads need locked delay loop; termination needs it only outside power-down
// - Internal write starts WL plus 4 or 2
// - Power-down current waits for refresh and for activate or precharge
// - Short calibration finishes within 64 cycles
`ifndef DDR3_GUARD_DEFINES_SVH
`define DDR3_GUARD_DEFINES_SVH

`define REG_CFG 8'h00
`define REG_STATUS 8'h04
`define REG_ZQCOUNT 8'h08
`define CFG_RESET 32'h0640b168
`define CFG_WL_LSB 0
`define CFG_RL_LSB 5
`define CFG_WR_LSB 10
`define CFG_WRREC_LSB 15
`define CFG_BC4_BIT 20
`define CFG_HOT_BIT 21
`define CFG_DLL_BIT 22
`define CFG_MOD_LSB 23
`define CFG_OTF_BIT 28
`define VIOL_W 11

`define CLK_PERIOD_NS 5.0
`define LINK_PERIOD_NS 160.0
`define REFRESH_CYCLE_TIME_NS 110.0
`define REFRESH_CYCLE_TIME_CYC 8'($rtoi($ceil(`REFRESH_CYCLE_TIME_NS / `LINK_PERIOD_NS)))
`define AVERAGE_REFRESH_INTERVAL_NORM_US 7.8
`define AVERAGE_REFRESH_INTERVAL_HOT_US 3.9
`define AVERAGE_REFRESH_INTERVAL_NORM_CYC 11'($rtoi(`AVERAGE_REFRESH_INTERVAL_NORM_US * 1000.0 / `CLK_PERIOD_NS + 0.001))
`define AVERAGE_REFRESH_INTERVAL_HOT_CYC 11'($rtoi(`AVERAGE_REFRESH_INTERVAL_HOT_US * 1000.0 / `CLK_PERIOD_NS + 0.001))
`define REF_DEBT_MAX 4'h8
`define REFPD_CYC 8'h01
`define PD_WR_BC4 8'h02
`define PD_WR_BL8 8'h04
`define WRA_EXTRA 8'h01
`define PD_RD_EXTRA 8'h05
`define ODT_LAT_SUB 5'h02
`define ODT_HIGH_SHORT 4'h4
`define ODT_HIGH_LONG 4'h6
`define WR_START_BC4 6'h02
`define WR_START_BL8 6'h04
`define LVL_FIRST_STROBE 6'h28
`define LVL_STROBE_EN 6'h19
`define POWERDOWN_EXIT_LOCKED_DELAY_CYC 4'ha
`define ZQCS_CYC 7'h40

`endif

// ### src/ddr3_guard_pkg.sv
// Types shared by the DDR3 command timing guard
`default_nettype none
`include "ddr3_guard_defines.svh"
package ddr3_guard_pkg;
  typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS, CMD_ZQ} cmd_t;
  // Order matches the low violation bits
  typedef enum logic [1:0] {CAUSE_WR, CAUSE_REF, CAUSE_MRS, CAUSE_RD} cause_t;
  typedef logic [`VIOL_W-1:0] viol_t;
endpackage
`default_nettype wire

// ### src/ddr3_command_timing_guard.sv
// DDR3 command timing guard: link sampling, spacing checks, device timing outputs
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`default_nettype none
`include "ddr3_guard_defines.svh"
module ddr3_command_timing_guard
  import ddr3_guard_pkg::*;
#(
  parameter int HIST_W = 64
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic ack_o,
  output logic [31:0] dat_o,
  input wire logic ckLink,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [2:0] ba,
  input wire logic a7,
  input wire logic a10,
  input wire logic a12,
  input wire logic cke,
  input wire logic odt,
  input wire logic dqs,
  input wire logic dqsEn,
  output logic termEn,
  output logic intWrite,
  output logic pdCurrent,
  output logic zqBusy
);
  localparam int IW = $clog2(HIST_W);

  function automatic cmd_t decodeCmd(input logic [3:0] p);
    if (p[3]) return CMD_NOP;
    case (p[2:0])
      3'h0: return CMD_MRS;
      3'h1: return CMD_REF;
      3'h2: return CMD_PRE;
      3'h3: return CMD_ACT;
      3'h4: return CMD_WR;
      3'h5: return CMD_RD;
      3'h6: return CMD_ZQ;
      default: return CMD_NOP;
    endcase
  endfunction

  // -------------------------------------------------------------
  // State
  // -------------------------------------------------------------
  logic [14:0] syncA_reg, syncA_next, syncB_reg, syncB_next;
  logic ckPrev_reg, ckPrev_next, ckePrev_reg, ckePrev_next, odtPrev_reg, odtPrev_next, dqsPrev_reg, dqsPrev_next;
  logic [31:0] cfg_reg, cfg_next, dat_next;
  viol_t viol_reg, viol_next, setV;
  logic [15:0] zqCount_reg, zqCount_next;
  logic ack_next, termEn_next, intWrite_next, pdCurrent_next, zqBusy_next;
  logic [7:0] pdGap_reg, pdGap_next, rfcCnt_reg, rfcCnt_next, gap;
  cause_t pdCause_reg, pdCause_next;
  logic pdActive_reg, pdActive_next, pdAfterRef_reg, pdAfterRef_next, actBusy_reg, actBusy_next;
  logic [3:0] exitLock_reg, exitLock_next, odtRun_reg, odtRun_next, refDebt_reg, refDebt_next;
  logic odtWr_reg, odtWr_next, level_reg, level_next;
  logic [HIST_W-1:0] odtHist_reg, odtHist_next, wrHist_reg, wrHist_next;
  logic [5:0] levelCnt_reg, levelCnt_next;
  logic [6:0] zqCnt_reg, zqCnt_next;
  logic [10:0] refTick_reg, refTick_next;

  // -------------------------------------------------------------
  // Synchronised link pins
  // -------------------------------------------------------------
  logic sCk, sCke, sOdt, sDqs, sDqsEn, sA7, sA10, sA12, linkRise, bc4Burst;
  logic [3:0] sCmd;
  logic [2:0] sBa;
  logic [4:0] wl, rl, wr, wrRec, modCyc, odtLat;
  logic bc4Fixed, hot, dllLocked, otfEn, busHit, wbWrite;
  logic [IW-1:0] wrIdx;
  cmd_t cmd;
  assign {sCk, sCmd, sBa, sA7, sA10, sA12, sCke, sOdt, sDqs, sDqsEn} = syncB_reg;
  assign linkRise = sCk & ~ckPrev_reg;
  assign cmd = linkRise ? decodeCmd(sCmd) : CMD_NOP;
  assign wl = cfg_reg[`CFG_WL_LSB +: 5];
  assign rl = cfg_reg[`CFG_RL_LSB +: 5];
  assign wr = cfg_reg[`CFG_WR_LSB +: 5];
  assign wrRec = cfg_reg[`CFG_WRREC_LSB +: 5];
  assign modCyc = cfg_reg[`CFG_MOD_LSB +: 5];
  assign bc4Fixed = cfg_reg[`CFG_BC4_BIT];
  assign hot = cfg_reg[`CFG_HOT_BIT];
  assign dllLocked = cfg_reg[`CFG_DLL_BIT];
  assign otfEn = cfg_reg[`CFG_OTF_BIT];
  assign bc4Burst = bc4Fixed | (otfEn & ~sA12);
  assign odtLat = (wl > `ODT_LAT_SUB) ? wl - `ODT_LAT_SUB : 5'h00;
  assign wrIdx = IW'({1'b0, wl} + (bc4Fixed ? `WR_START_BC4 : `WR_START_BL8));
  assign busHit = cyc_i & stb_i;
  assign wbWrite = busHit & we_i & ack_o;

  // -------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------
  always_comb begin
    syncA_next = {ckLink, csN, rasN, casN, weN, ba, a7, a10, a12, cke, odt, dqs, dqsEn};
    syncB_next = syncA_reg;
    ckPrev_next = sCk;
    cfg_next = cfg_reg;
    setV = '0;
    zqCount_next = zqCount_reg;
    pdGap_next = pdGap_reg;
    pdCause_next = pdCause_reg;
    rfcCnt_next = rfcCnt_reg;
    actBusy_next = actBusy_reg;
    pdActive_next = pdActive_reg;
    pdAfterRef_next = pdAfterRef_reg;
    exitLock_next = exitLock_reg;
    odtRun_next = odtRun_reg;
    odtWr_next = odtWr_reg;
    odtHist_next = odtHist_reg;
    wrHist_next = wrHist_reg;
    level_next = level_reg;
    levelCnt_next = levelCnt_reg;
    zqCnt_next = zqCnt_reg;
    ckePrev_next = ckePrev_reg;
    odtPrev_next = odtPrev_reg;
    dqsPrev_next = dqsPrev_reg;
    intWrite_next = 1'b0;
    termEn_next = termEn;
    gap = 8'h00;
    if (linkRise) begin
      ckePrev_next = sCke;
      odtPrev_next = sOdt;
      dqsPrev_next = sDqs;
      // Remaining-cycle counters; a value above one means the spacing is still running
      if (pdGap_reg != 8'h00) pdGap_next = pdGap_reg - 8'h01;
      if (rfcCnt_reg != 8'h00) rfcCnt_next = rfcCnt_reg - 8'h01;
      if (exitLock_reg != 4'h0) exitLock_next = exitLock_reg - 4'h1;
      actBusy_next = (cmd == CMD_ACT) || (cmd == CMD_PRE);
      case (cmd)
        CMD_WR: begin
          if (sA10) gap = 8'(wl) + (bc4Fixed ? `PD_WR_BC4 : `PD_WR_BL8) + 8'(wr) + `WRA_EXTRA;
          else gap = 8'(wl) + (bc4Fixed ? `PD_WR_BC4 : `PD_WR_BL8) + 8'(wrRec);
        end
        CMD_RD: begin
          gap = 8'(rl) + `PD_RD_EXTRA;
          if (!dllLocked) setV[9] = 1'b1;
          if (exitLock_reg > 4'h1) setV[10] = 1'b1;
        end
        CMD_REF: begin
          gap = `REFPD_CYC;
          if (rfcCnt_reg > 8'h01) setV[7] = 1'b1;
          rfcCnt_next = `REFRESH_CYCLE_TIME_CYC;
        end
        CMD_ACT: begin
          if (rfcCnt_reg > 8'h01) setV[7] = 1'b1;
        end
        CMD_MRS: begin
          gap = 8'(modCyc);
          if (sBa == 3'h1) begin
            level_next = sA7;
            levelCnt_next = 6'h00;
          end
        end
        CMD_ZQ: begin
          if (!sA10) zqCnt_next = `ZQCS_CYC;
        end
        default: ;
      endcase
      if (gap > pdGap_next) begin
        pdGap_next = gap;
        pdCause_next = (cmd == CMD_WR) ? CAUSE_WR : (cmd == CMD_RD) ? CAUSE_RD :
                       (cmd == CMD_REF) ? CAUSE_REF : CAUSE_MRS;
      end
      // Power-down entry and exit
      if (ckePrev_reg && !sCke) begin
        pdActive_next = 1'b1;
        pdAfterRef_next = rfcCnt_reg != 8'h00;
        if (pdGap_reg > 8'h01) setV[pdCause_reg] = 1'b1;
      end else if (!ckePrev_reg && sCke && pdActive_reg) begin
        pdActive_next = 1'b0;
        if (pdAfterRef_reg) exitLock_next = `POWERDOWN_EXIT_LOCKED_DELAY_CYC;
      end
      // Termination pulse width and latency
      if (sOdt) begin
        if (odtRun_reg != 4'hf) odtRun_next = odtRun_reg + 4'h1;
        if (cmd == CMD_WR && !bc4Burst) odtWr_next = 1'b1;
        if (!odtPrev_reg && !dllLocked && !pdActive_reg) setV[9] = 1'b1;
      end else begin
        odtRun_next = 4'h0;
        odtWr_next = 1'b0;
        if (odtPrev_reg && odtRun_reg < (odtWr_reg ? `ODT_HIGH_LONG : `ODT_HIGH_SHORT)) setV[4] = 1'b1;
      end
      odtHist_next = {odtHist_reg[HIST_W-2:0], sOdt};
      termEn_next = odtHist_next[odtLat];
      wrHist_next = {wrHist_reg[HIST_W-2:0], cmd == CMD_WR};
      intWrite_next = wrHist_next[wrIdx];
      // Write leveling strobe timing
      if (level_reg && cmd != CMD_MRS) begin
        if (levelCnt_reg != 6'h3f) levelCnt_next = levelCnt_reg + 6'h01;
        if (sDqs && !dqsPrev_reg && levelCnt_reg < `LVL_FIRST_STROBE) setV[5] = 1'b1;
        if (sDqsEn && levelCnt_reg < `LVL_STROBE_EN) setV[6] = 1'b1;
      end
      if (zqCnt_reg != 7'h00 && cmd != CMD_ZQ) begin
        zqCnt_next = zqCnt_reg - 7'h01;
        if (zqCnt_reg == 7'h01) zqCount_next = zqCount_reg + 16'h0001;
      end
    end
    // Refresh debt: each elapsed interval adds one, each refresh pays one
    refTick_next = refTick_reg + 11'h001;
    refDebt_next = refDebt_reg;
    if (refTick_reg >= (hot ? `AVERAGE_REFRESH_INTERVAL_HOT_CYC : `AVERAGE_REFRESH_INTERVAL_NORM_CYC) - 11'h001) begin
      refTick_next = 11'h000;
      if (cmd != CMD_REF && refDebt_reg != 4'hf) refDebt_next = refDebt_reg + 4'h1;
    end else if (cmd == CMD_REF && refDebt_reg != 4'h0) begin
      refDebt_next = refDebt_reg - 4'h1;
    end
    if (refDebt_reg > `REF_DEBT_MAX) setV[8] = 1'b1;
    pdCurrent_next = pdActive_reg && rfcCnt_reg == 8'h00 && !actBusy_reg;
    zqBusy_next = zqCnt_reg != 7'h00;
    // Register bus; a set in the same cycle as a clear wins
    viol_next = viol_reg | setV;
    if (wbWrite && adr_i == `REG_CFG) begin
      for (int b = 0; b < 4; b++) begin
        if (sel_i[b]) cfg_next[8*b +: 8] = dat_i[8*b +: 8];
      end
    end else if (wbWrite && adr_i == `REG_STATUS && sel_i[0] && sel_i[1]) begin
      viol_next = (viol_reg & ~dat_i[`VIOL_W-1:0]) | setV;
    end
    ack_next = busHit & ~ack_o;
    dat_next = 32'h0000_0000;
    if (adr_i == `REG_CFG) begin
      dat_next = cfg_reg;
    end else if (adr_i == `REG_STATUS) begin
      dat_next = {4'h0, refDebt_reg, 3'h0, level_reg, zqBusy, termEn, pdCurrent, pdActive_reg, 5'h00, viol_reg};
    end else if (adr_i == `REG_ZQCOUNT) begin
      dat_next = {16'h0000, zqCount_reg};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
      {ckPrev_reg, ckePrev_reg, odtPrev_reg, dqsPrev_reg} <= 4'h0;
      cfg_reg <= `CFG_RESET;
      viol_reg <= '0;
      zqCount_reg <= 16'h0000;
      {ack_o, termEn, intWrite, pdCurrent, zqBusy} <= 5'h00;
      dat_o <= 32'h0000_0000;
      pdGap_reg <= 8'h00;
      pdCause_reg <= CAUSE_WR;
      rfcCnt_reg <= 8'h00;
      {actBusy_reg, pdActive_reg, pdAfterRef_reg, odtWr_reg, level_reg} <= 5'h00;
      {exitLock_reg, odtRun_reg, refDebt_reg} <= 12'h000;
      odtHist_reg <= '0;
      wrHist_reg <= '0;
      levelCnt_reg <= 6'h00;
      zqCnt_reg <= 7'h00;
      refTick_reg <= 11'h000;
    end else if (ce) begin
      syncA_reg <= syncA_next;
      syncB_reg <= syncB_next;
      {ckPrev_reg, ckePrev_reg, odtPrev_reg, dqsPrev_reg} <= {ckPrev_next, ckePrev_next, odtPrev_next, dqsPrev_next};
      cfg_reg <= cfg_next;
      viol_reg <= viol_next;
      zqCount_reg <= zqCount_next;
      {ack_o, termEn, intWrite, pdCurrent, zqBusy} <= {ack_next, termEn_next, intWrite_next, pdCurrent_next, zqBusy_next};
      dat_o <= dat_next;
      pdGap_reg <= pdGap_next;
      pdCause_reg <= pdCause_next;
      rfcCnt_reg <= rfcCnt_next;
      {actBusy_reg, pdActive_reg, pdAfterRef_reg, odtWr_reg, level_reg} <=
        {actBusy_next, pdActive_next, pdAfterRef_next, odtWr_next, level_next};
      {exitLock_reg, odtRun_reg, refDebt_reg} <= {exitLock_next, odtRun_next, refDebt_next};
      odtHist_reg <= odtHist_next;
      wrHist_reg <= wrHist_next;
      levelCnt_reg <= levelCnt_next;
      zqCnt_reg <= zqCnt_next;
      refTick_reg <= refTick_next;
    end
  end

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || !ce);

  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held two cycles");
  a_term_latency: assert property (linkRise |=> termEn == $past(odtHist_next[odtLat])) else $error("term latency");
  a_write_start: assert property (intWrite |-> wrHist_reg[wrIdx] && !$past(intWrite)) else $error("write start");
  a_pd_spacing: assert property (linkRise && ckePrev_reg && !sCke && pdGap_reg > 8'h01
    |=> viol_reg[$past(pdCause_reg)]) else $error("pd spacing missed");
  a_rfc_window: assert property ($rose(viol_reg[7]) |-> $past(rfcCnt_reg) > 8'h01) else $error("rfc flag");
  a_refi_debt: assert property (refDebt_reg > `REF_DEBT_MAX |=> viol_reg[8]) else $error("refresh debt");
  a_dll_read: assert property (cmd == CMD_RD && !dllLocked |=> viol_reg[9]) else $error("unlocked read");
  a_odt_width: assert property ($rose(viol_reg[4]) |-> $past(odtPrev_reg && !sOdt && linkRise)) else $error("odt flag");
  a_pd_current: assert property (pdCurrent |-> $past(pdActive_reg && rfcCnt_reg == 8'h00)) else $error("pd current");
  a_zq_bound: assert property (zqCnt_reg <= `ZQCS_CYC) else $error("zq count");
  a_level_strobe: assert property ($rose(viol_reg[5]) |-> $past(level_reg && levelCnt_reg < `LVL_FIRST_STROBE))
    else $error("leveling flag");
  a_exit_lock: assert property (cmd == CMD_RD && exitLock_reg > 4'h1 |=> viol_reg[10]) else $error("exit lock");

  c_pd_entry: cover property (pdActive_reg ##1 pdCurrent);
  c_int_write: cover property (intWrite);
  c_refresh_early: cover property ($rose(viol_reg[7]));
  c_zq_done: cover property ($fell(zqBusy));
endmodule
`default_nettype wire

// ### verification/ddr3_ctrl_model.sv
// Behavioural DDR3 controller driving the command link
`default_nettype none
module ddr3_ctrl_model
  import ddr3_guard_pkg::*;
(
  input wire logic ref_clk,
  output logic ckLink,
  output logic csN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic [2:0] ba,
  output logic a7,
  output logic a10,
  output logic a12,
  output logic cke,
  output logic odt,
  output logic dqs,
  output logic dqsEn,
  output logic [15:0] lc
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pin codes in the order of cmd_t
  localparam logic [3:0] ENC [8] = '{4'h7, 4'h3, 4'h5, 4'h4, 4'h2, 4'h1, 4'h0, 4'h6};
  logic [3:0] div = 4'h0;
  initial begin
    ckLink = 1'b0;
    lc = 16'h0000;
    {csN, rasN, casN, weN, ba, a7, a10, a12} = 10'h3c1;
    {cke, odt, dqs, dqsEn} = 4'h8;
  end
  // Link clock runs free at 16 system cycles per half period
  always @(posedge ref_clk) begin
    div <= div + 4'h1;
    if (div == 4'hf) begin
      ckLink <= ~ckLink;
      if (!ckLink) lc <= lc + 16'h0001;
    end
  end
  // Pins change only on the falling link edge
  task automatic cmd(input cmd_t c, input logic [2:0] b, input logic x7, input logic x10, output logic [15:0] at);
    @(negedge ckLink);
    {csN, rasN, casN, weN} <= ENC[c];
    {ba, a7, a10} <= {b, x7, x10};
    @(posedge ckLink);
    @(negedge ref_clk);
    at = lc;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge ckLink);
      {csN, rasN, casN, weN} <= 4'hf;
    end
  endtask
  // Burst chop on the fly is asked for by holding a12 low
  task automatic chop(input logic v);
    @(negedge ckLink);
    a12 <= ~v;
  endtask
  task automatic pins(input logic [3:0] v);
    @(negedge ckLink);
    {csN, rasN, casN, weN} <= 4'hf;
    {cke, odt, dqs, dqsEn} <= v;
  endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the DDR3 command timing guard
`default_nettype none
`include "ddr3_guard_defines.svh"
module testbench
  import ddr3_guard_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WL = 5;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic ack, ckLink, csN, rasN, casN, weN, a7, a10, a12, cke, odt, dqs, dqsEn;
  logic termEn, intWrite, pdCurrent, zqBusy, tePrev;
  logic [2:0] ba;
  logic [31:0] rdat, rd;
  logic [15:0] lc, at, iwAt, tmAt, tfAt;
  int errCount = 0;
  int numChecks = 0;
  initial forever #2.5 ref_clk = ~ref_clk;
  ddr3_command_timing_guard dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .dat_i(wdat), .sel_i(sel), .ack_o(ack), .dat_o(rdat), .ckLink(ckLink), .csN(csN), .rasN(rasN),
    .casN(casN), .weN(weN), .ba(ba), .a7(a7), .a10(a10), .a12(a12), .cke(cke), .odt(odt), .dqs(dqs),
    .dqsEn(dqsEn), .termEn(termEn), .intWrite(intWrite), .pdCurrent(pdCurrent), .zqBusy(zqBusy));
  ddr3_ctrl_model pm (.ref_clk(ref_clk), .ckLink(ckLink), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
    .ba(ba), .a7(a7), .a10(a10), .a12(a12), .cke(cke), .odt(odt), .dqs(dqs), .dqsEn(dqsEn), .lc(lc));
  // Link cycle of each internal write and termination edge
  always @(posedge ref_clk) begin
    tePrev <= termEn;
    if (intWrite === 1'b1) iwAt <= lc;
    if (termEn === 1'b1 && tePrev === 1'b0) tmAt <= lc;
    if (termEn === 1'b0 && tePrev === 1'b1) tfAt <= lc;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrapUp;
    $display("Checks %0d errors %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      errCount++;
      wrapUp();
    end
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  // Status violations are compared without the refresh debt flag, then cleared
  task automatic stat(input logic [10:0] e);
    wb(1'b0, `REG_STATUS, 32'h0, rd);
    check({21'h0, rd[10:0] & 11'h6ff}, {21'h0, e});
    wb(1'b1, `REG_STATUS, 32'h7ff, rd);
  endtask
  task automatic setcfg(input logic b4, input logic dll, input logic hot);
    wb(1'b1, `REG_CFG, WL | (6 << `CFG_RL_LSB) | (6 << `CFG_WR_LSB) | (6 << `CFG_WRREC_LSB) | (b4 << `CFG_BC4_BIT)
      | (hot << `CFG_HOT_BIT) | (dll << `CFG_DLL_BIT) | (12 << `CFG_MOD_LSB) | (1 << `CFG_OTF_BIT), rd);
  endtask
  // Command, then CKE low sampled at link cycle cy after it
  task automatic pd(input logic b4, input cmd_t c, input logic x10, input int cy, input logic [10:0] e);
    setcfg(b4, 1'b1, 1'b0);
    pm.cmd(c, 3'h0, 1'b0, x10, at);
    pm.idle(cy - 1);
    pm.pins(4'h0);
    pm.idle(2);
    pm.pins(4'h8);
    pm.idle(12);
    stat(e);
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    wb(1'b0, `REG_CFG, 32'h0, rd);
    check(rd, `CFG_RESET);
    wb(1'b0, 8'h10, 32'h0, rd);
    check(rd, 32'h0);
    stat(11'h000);
    for (int i = 0; i < 2; i++) begin
      setcfg(i[0], 1'b1, 1'b0);
      pm.cmd(CMD_WR, 3'h0, 1'b0, 1'b0, at);
      pm.idle(14);
      check({16'h0, iwAt}, {16'h0, at + 16'(WL + (i ? 2 : 4))});
    end
    pd(1'b0, CMD_WR, 1'b0, 14, 11'h001);
    pd(1'b0, CMD_WR, 1'b0, 15, 11'h000);
    pd(1'b1, CMD_WR, 1'b0, 12, 11'h001);
    pd(1'b1, CMD_WR, 1'b0, 13, 11'h000);
    pd(1'b1, CMD_WR, 1'b1, 13, 11'h001);
    pd(1'b1, CMD_WR, 1'b1, 14, 11'h000);
    pd(1'b0, CMD_RD, 1'b0, 10, 11'h008);
    pd(1'b0, CMD_RD, 1'b0, 11, 11'h000);
    pd(1'b0, CMD_MRS, 1'b0, 11, 11'h004);
    pd(1'b0, CMD_MRS, 1'b0, 12, 11'h000);
    pd(1'b0, CMD_REF, 1'b0, 1, 11'h000);
    pm.cmd(CMD_REF, 3'h0, 1'b0, 1'b0, at);
    pm.cmd(CMD_ACT, 3'h0, 1'b0, 1'b0, at);
    pm.idle(2);
    stat(11'h000);
    // Power-down entered while refresh runs arms the locked exit delay
    pm.cmd(CMD_REF, 3'h0, 1'b0, 1'b0, at);
    pm.pins(4'h0);
    pm.idle(2);
    check({31'h0, pdCurrent}, 32'h1);
    pm.pins(4'h8);
    pm.cmd(CMD_RD, 3'h0, 1'b0, 1'b0, at);
    pm.idle(14);
    check({31'h0, pdCurrent}, 32'h0);
    stat(11'h400);
    for (int i = 0; i < 2; i++) begin
      pm.pins(4'hc);
      @(posedge ckLink);
      @(negedge ref_clk);
      at = lc;
      pm.idle(i ? 3 : 1);
      pm.pins(4'h8);
      pm.idle(10);
      check({16'h0, tmAt}, {16'h0, at + 16'(WL - 2)});
      check({16'h0, tfAt - tmAt}, i ? 32'h4 : 32'h2);
      stat(i ? 11'h000 : 11'h010);
    end
    // Four cycles of termination around a write: too short for eight beats, enough for a chop
    for (int i = 0; i < 2; i++) begin
      pm.chop(i[0]);
      pm.pins(4'hc);
      pm.cmd(CMD_WR, 3'h0, 1'b0, 1'b0, at);
      pm.idle(2);
      pm.pins(4'h8);
      pm.idle(20);
      stat(i ? 11'h000 : 11'h010);
    end
    pm.chop(1'b0);
    for (int i = 0; i < 2; i++) begin
      pm.cmd(CMD_MRS, 3'h1, 1'b1, 1'b0, at);
      pm.idle(i ? 30 : 10);
      pm.pins(4'h9);
      pm.idle(i ? 12 : 8);
      pm.pins(4'hb);
      pm.idle(2);
      pm.pins(4'h8);
      pm.cmd(CMD_MRS, 3'h1, 1'b0, 1'b0, at);
      pm.idle(14);
      stat(i ? 11'h000 : 11'h060);
    end
    setcfg(1'b0, 1'b0, 1'b0);
    pm.cmd(CMD_RD, 3'h0, 1'b0, 1'b0, at);
    pm.idle(14);
    stat(11'h200);
    setcfg(1'b0, 1'b1, 1'b0);
    pm.cmd(CMD_ZQ, 3'h0, 1'b0, 1'b0, at);
    pm.idle(2);
    check({31'h0, zqBusy}, 32'h1);
    // Clock enable low freezes the calibration count
    ce <= 1'b0;
    pm.idle(70);
    check({31'h0, zqBusy}, 32'h1);
    ce <= 1'b1;
    pm.idle(58);
    check({31'h0, zqBusy}, 32'h1);
    pm.idle(8);
    check({31'h0, zqBusy}, 32'h0);
    wb(1'b0, `REG_ZQCOUNT, 32'h0, rd);
    check(rd, 32'h1);
    setcfg(1'b0, 1'b1, 1'b1);
    pm.idle(500);
    wb(1'b0, `REG_STATUS, 32'h0, rd);
    check({31'h0, rd[8]}, 32'h1);
    wrapUp();
  end
endmodule
`default_nettype wire
